// ==== shared/gpio_pkg.sv ====
// Shared constants and types for the port, pin interrupt and pattern logic
package gpio_pkg;

  // --------------------------------------------------------------------------
  // Geometry
  // --------------------------------------------------------------------------
  localparam int NUM_PORTS    = 2;
  localparam int PORT_WIDTH   = 32;
  localparam int NUM_PINS     = NUM_PORTS * PORT_WIDTH;
  localparam int NUM_LANES    = PORT_WIDTH / 8;
  localparam int NUM_GROUPS   = 2;
  localparam int NUM_CHANNELS = 8;
  localparam int SEL_WIDTH    = 6;
  localparam int SRC_WIDTH    = 3;

  // --------------------------------------------------------------------------
  // Values after reset
  // --------------------------------------------------------------------------
  localparam logic [PORT_WIDTH-1:0] DIR_RESET  = 32'h0000_0000;
  localparam logic [PORT_WIDTH-1:0] OUT_RESET  = 32'h0000_0000;
  localparam logic [PORT_WIDTH-1:0] MASK_RESET = 32'h0000_0000;
  localparam logic [NUM_PINS-1:0]   PIN_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [1:0]            UP_DONE    = 2'h3;

  // --------------------------------------------------------------------------
  // Port operations and pattern slice conditions
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_DIR,
    OP_MASK,
    OP_PORT,
    OP_MPORT,
    OP_SET,
    OP_CLR,
    OP_NOT
  } gpio_op_t;

  typedef enum logic [2:0] {
    PM_ALWAYS,
    PM_HIGH,
    PM_LOW,
    PM_RISE,
    PM_FALL,
    PM_EDGE
  } pm_cond_t;

endpackage : gpio_pkg

// ==== shared/sel_pins_if.sv ====
// Selected pin levels passed from the port logic to the pin interrupt unit
interface sel_pins_if #(
  parameter int N = 8
);
  logic [N-1:0] raw;
  logic [N-1:0] now;
  logic [N-1:0] prev;

  modport provider (output raw, output now, output prev);
  modport consumer (input raw, input now, input prev);
endinterface : sel_pins_if

// ==== src/pin_irq_unit.sv ====
// Eight-channel pin interrupt unit with edge and level sensing
module pin_irq_unit
  import gpio_pkg::*;
#(
  parameter int N = NUM_CHANNELS
) (
  // Clock and reset
  input  logic         clk_i,
  input  logic         resetn_i,
  // Selected pins
  sel_pins_if.consumer sel,
  // Channel configuration
  input  logic [N-1:0] level_mode_i,
  input  logic [N-1:0] rise_en_i,
  input  logic [N-1:0] fall_en_i,
  input  logic [N-1:0] active_high_i,
  input  logic [N-1:0] clear_i,
  // Requests
  output logic [N-1:0] irq_o,
  output logic         wake_o
);

  logic [N-1:0] edge_flag;
  logic [N-1:0] edge_set;
  logic [N-1:0] level_req;
  logic [N-1:0] level_raw;

  assign edge_set  = ~level_mode_i & ((sel.now & ~sel.prev & rise_en_i)
                                    | (~sel.now & sel.prev & fall_en_i));
  assign level_req = level_mode_i & rise_en_i & ~(sel.now ^ active_high_i);
  assign level_raw = level_mode_i & rise_en_i & ~(sel.raw ^ active_high_i);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      edge_flag <= '0;
    end else begin
      edge_flag <= edge_set | (edge_flag & ~clear_i);
    end
  end

  assign irq_o  = (level_mode_i & level_req) | (~level_mode_i & edge_flag);
  // Raw level path keeps waking while the clock is stopped
  assign wake_o = (|edge_flag) | (|level_raw);

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  property p_edge_rise;
    @(posedge clk_i) disable iff (!resetn_i)
      (!level_mode_i[0] && rise_en_i[0] && sel.now[0] && !sel.prev[0]) |=> irq_o[0] || level_mode_i[0];
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rising edge not latched");

  property p_level;
    @(posedge clk_i) disable iff (!resetn_i)
      (level_mode_i[3] && rise_en_i[3]) |-> (irq_o[3] == (sel.now[3] == active_high_i[3]));
  endproperty
  a_level: assert property (p_level) else $error("level request mismatch");

  property p_clear;
    @(posedge clk_i) disable iff (!resetn_i)
      (clear_i[2] && !edge_set[2] && !level_mode_i[2]) ##1 !level_mode_i[2] |-> !irq_o[2];
  endproperty
  a_clear: assert property (p_clear) else $error("edge flag survived clear");

  c_edge_irq: cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(edge_flag[0]));

endmodule : pin_irq_unit

// ==== src/gpio_pin_interrupt_pattern.sv ====
// Two-port GPIO with grouped interrupts, pin interrupts and pattern match
//
// Notes on behaviour
// - Two ports give sixty-four pins
// - All pins inputs after reset; per-pin direction
// - Set and clear writes touch selected bits
// - Toggle write inverts ones-written output bits
// - Mask hides bits from masked reads, writes
// - Byte enables limit writes to addressed lanes
// - Readback shows real pad level always
// - Two grouped interrupts with own patterns
// - Grouped interrupts work with clock stopped
// - Eight selectable pins, one interrupt each
// - Edge mode: rising, falling or both
// - Level mode: request while pin active
// - Pin interrupts wake from sleep; from deep-sleep in level mode only
// - Any pin routable into interrupt engines
// - Pattern built from levels and transitions
// - Each product term has own interrupt
// - Match optionally pulses processor event output
// - Pattern wake only while clock runs
// - Accesses complete in one cycle
// - Output levels held static by flops
module gpio_pin_interrupt_pattern
  import gpio_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
) (
  // Clock and reset
  input  logic                                 clk_i,
  input  logic                                 resetn_i,
  // Port operation strobe
  input  logic                                 op_valid_i,
  input  gpio_op_t                             op_kind_i,
  input  logic                                 op_port_i,
  input  logic [PORT_WIDTH-1:0]                op_data_i,
  input  logic [NUM_LANES-1:0]                 op_be_i,
  // Port read strobe
  input  logic                                 rd_valid_i,
  input  gpio_op_t                             rd_kind_i,
  input  logic                                 rd_port_i,
  input  logic [NUM_LANES-1:0]                 rd_be_i,
  output logic                                 rd_valid_o,
  output logic [PORT_WIDTH-1:0]                rd_data_o,
  // Pins
  input  logic [NUM_PINS-1:0]                  gpio_in_i,
  output logic [NUM_PINS-1:0]                  gpio_out_o,
  output logic [NUM_PINS-1:0]                  gpio_oe_o,
  output logic [NUM_PINS-1:0]                  pin_level_o,
  // Grouped interrupts
  input  logic [NUM_GROUPS-1:0][NUM_PINS-1:0]  grp_en_i,
  input  logic [NUM_GROUPS-1:0][NUM_PINS-1:0]  grp_high_i,
  input  logic [NUM_GROUPS-1:0]                grp_and_i,
  output logic [NUM_GROUPS-1:0]                grouped_irq_o,
  // Pin interrupts
  input  logic [CHANNELS-1:0][SEL_WIDTH-1:0]   pint_sel_i,
  input  logic [CHANNELS-1:0]                  pint_level_mode_i,
  input  logic [CHANNELS-1:0]                  pint_rise_i,
  input  logic [CHANNELS-1:0]                  pint_fall_i,
  input  logic [CHANNELS-1:0]                  pint_active_high_i,
  input  logic [CHANNELS-1:0]                  pint_clear_i,
  output logic [CHANNELS-1:0]                  pint_irq_o,
  output logic                                 pint_wake_o,
  // Pattern match engine
  input  logic [CHANNELS-1:0][SRC_WIDTH-1:0]   pm_src_i,
  input  pm_cond_t [CHANNELS-1:0]              pm_cond_i,
  input  logic [CHANNELS-1:0]                  pm_end_i,
  input  logic                                 pm_event_en_i,
  output logic [CHANNELS-1:0]                  pm_irq_o,
  output logic                                 cpu_event_notify_o
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [PORT_WIDTH-1:0] lane_mask(input logic [NUM_LANES-1:0] be);
    lane_mask = '0;
    for (int b = 0; b < NUM_LANES; b++) begin
      lane_mask[b*8 +: 8] = {8{be[b]}};
    end
  endfunction : lane_mask

  function automatic logic [PORT_WIDTH-1:0] merge(input logic [PORT_WIDTH-1:0] old_v,
                                                  input logic [PORT_WIDTH-1:0] new_v,
                                                  input logic [PORT_WIDTH-1:0] en);
    merge = (old_v & ~en) | (new_v & en);
  endfunction : merge

  // --------------------------------------------------------------------------
  // Port state
  // --------------------------------------------------------------------------
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] dir;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] port_out;
  logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] mask;
  logic [PORT_WIDTH-1:0]                wr_lanes;
  logic [PORT_WIDTH-1:0]                wr_bits;
  logic [PORT_WIDTH-1:0]                rd_lanes;

  assign wr_lanes = lane_mask(op_be_i);
  assign wr_bits  = op_data_i & wr_lanes;
  assign rd_lanes = lane_mask(rd_be_i);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dir <= {NUM_PORTS{DIR_RESET}};
    end else if (op_valid_i && op_kind_i == OP_DIR) begin
      dir[op_port_i] <= merge(dir[op_port_i], op_data_i, wr_lanes);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask <= {NUM_PORTS{MASK_RESET}};
    end else if (op_valid_i && op_kind_i == OP_MASK) begin
      mask[op_port_i] <= merge(mask[op_port_i], op_data_i, wr_lanes);
    end
  end

  // Output latch holds its level whenever no write arrives
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      port_out <= {NUM_PORTS{OUT_RESET}};
    end else if (op_valid_i) begin
      case (op_kind_i)
        OP_PORT: begin
          port_out[op_port_i] <= merge(port_out[op_port_i], op_data_i, wr_lanes);
        end
        OP_MPORT: begin
          port_out[op_port_i] <= merge(port_out[op_port_i], op_data_i, wr_lanes & ~mask[op_port_i]);
        end
        OP_SET: begin
          port_out[op_port_i] <= port_out[op_port_i] | wr_bits;
        end
        OP_CLR: begin
          port_out[op_port_i] <= port_out[op_port_i] & ~wr_bits;
        end
        OP_NOT: begin
          port_out[op_port_i] <= port_out[op_port_i] ^ wr_bits;
        end
        default: begin
          port_out <= port_out;
        end
      endcase
    end
  end

  assign gpio_out_o = port_out;
  assign gpio_oe_o  = dir;

  // --------------------------------------------------------------------------
  // Pin synchroniser
  // --------------------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_prev;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_meta <= PIN_RESET;
      pin_sync <= PIN_RESET;
      pin_prev <= PIN_RESET;
    end else begin
      pin_meta <= gpio_in_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  assign pin_level_o = pin_sync;

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  logic [PORT_WIDTH-1:0] next_rd_data;

  always_comb begin
    case (rd_kind_i)
      OP_DIR:   next_rd_data = dir[rd_port_i];
      OP_MASK:  next_rd_data = mask[rd_port_i];
      OP_PORT:  next_rd_data = pin_sync[rd_port_i*PORT_WIDTH +: PORT_WIDTH];
      OP_MPORT: next_rd_data = pin_sync[rd_port_i*PORT_WIDTH +: PORT_WIDTH] & ~mask[rd_port_i];
      OP_SET:   next_rd_data = port_out[rd_port_i];
      default:  next_rd_data = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else begin
      rd_valid_o <= rd_valid_i;
      rd_data_o  <= rd_valid_i ? (next_rd_data & rd_lanes) : '0;
    end
  end

  // --------------------------------------------------------------------------
  // Grouped interrupts, combinational from the pads
  // --------------------------------------------------------------------------
  logic [NUM_GROUPS-1:0][NUM_PINS-1:0] grp_hit;

  always_comb begin
    for (int g = 0; g < NUM_GROUPS; g++) begin
      grp_hit[g]       = ~(gpio_in_i ^ grp_high_i[g]) & grp_en_i[g];
      grouped_irq_o[g] = grp_and_i[g] ? ((grp_en_i[g] != '0) && (grp_hit[g] == grp_en_i[g]))
                                      : (|grp_hit[g]);
    end
  end

  // --------------------------------------------------------------------------
  // Pin selection shared by pin interrupts and pattern engine
  // --------------------------------------------------------------------------
  sel_pins_if #(.N(CHANNELS)) sel_bus ();

  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      sel_bus.raw[c]  = gpio_in_i[pint_sel_i[c]];
      sel_bus.now[c]  = pin_sync[pint_sel_i[c]];
      sel_bus.prev[c] = pin_prev[pint_sel_i[c]];
    end
  end

  pin_irq_unit #(
    .N (CHANNELS)
  ) pin_irq_unit_inst (
    .clk_i         (clk_i),
    .resetn_i      (resetn_i),
    .sel           (sel_bus),
    .level_mode_i  (pint_level_mode_i),
    .rise_en_i     (pint_rise_i),
    .fall_en_i     (pint_fall_i),
    .active_high_i (pint_active_high_i),
    .clear_i       (pint_clear_i),
    .irq_o         (pint_irq_o),
    .wake_o        (pint_wake_o)
  );

  // --------------------------------------------------------------------------
  // Pattern match engine
  // --------------------------------------------------------------------------
  logic [CHANNELS-1:0] next_pm_hit;
  logic                pm_bit;
  logic                pm_old;
  logic                pm_ok;
  logic                pm_term;

  // Slices chain into product terms; an end bit closes a term
  always_comb begin
    next_pm_hit = '0;
    pm_term     = 1'b1;
    pm_bit      = 1'b0;
    pm_old      = 1'b0;
    pm_ok       = 1'b0;
    for (int s = 0; s < CHANNELS; s++) begin
      pm_bit = sel_bus.now[pm_src_i[s]];
      pm_old = sel_bus.prev[pm_src_i[s]];
      case (pm_cond_i[s])
        PM_ALWAYS: pm_ok = 1'b1;
        PM_HIGH:   pm_ok = pm_bit;
        PM_LOW:    pm_ok = !pm_bit;
        PM_RISE:   pm_ok = pm_bit && !pm_old;
        PM_FALL:   pm_ok = !pm_bit && pm_old;
        PM_EDGE:   pm_ok = pm_bit ^ pm_old;
        default:   pm_ok = 1'b0;
      endcase
      pm_term = pm_term & pm_ok;
      if (pm_end_i[s] || s == CHANNELS - 1) begin
        next_pm_hit[s] = pm_term;
        pm_term        = 1'b1;
      end
    end
  end

  // Needs the clock, so it cannot wake from deeper states
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pm_irq_o           <= '0;
      cpu_event_notify_o <= 1'b0;
    end else begin
      pm_irq_o           <= next_pm_hit;
      cpu_event_notify_o <= pm_event_en_i && (|next_pm_hit);
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  logic [1:0] up_cnt;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_cnt <= '0;
    end else if (up_cnt != UP_DONE) begin
      up_cnt <= up_cnt + 2'h1;
    end
  end

  property p_dir_reset;
    @(posedge clk_i) disable iff (!resetn_i)
      (up_cnt == 2'h0) |-> (gpio_oe_o == '0);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("pins not inputs after reset");

  property p_set;
    @(posedge clk_i) disable iff (!resetn_i)
      (op_valid_i && op_kind_i == OP_SET) |=> ((port_out[$past(op_port_i)] & $past(wr_bits)) == $past(wr_bits));
  endproperty
  a_set: assert property (p_set) else $error("set write missed bits");

  property p_clr_keep;
    @(posedge clk_i) disable iff (!resetn_i)
      (op_valid_i && op_kind_i == OP_CLR) |=>
        (port_out[$past(op_port_i)] == ($past(port_out[op_port_i]) & ~$past(wr_bits)));
  endproperty
  a_clr_keep: assert property (p_clr_keep) else $error("clear write wrong");

  property p_toggle;
    @(posedge clk_i) disable iff (!resetn_i)
      (op_valid_i && op_kind_i == OP_NOT) |=>
        (port_out[$past(op_port_i)] == ($past(port_out[op_port_i]) ^ $past(wr_bits)));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle write wrong");

  property p_mask_keep;
    @(posedge clk_i) disable iff (!resetn_i)
      (op_valid_i && op_kind_i == OP_MPORT) |=>
        ((port_out[$past(op_port_i)] & $past(mask[op_port_i])) == $past(port_out[op_port_i] & mask[op_port_i]));
  endproperty
  a_mask_keep: assert property (p_mask_keep) else $error("masked bit changed");

  property p_lane_keep;
    @(posedge clk_i) disable iff (!resetn_i)
      (op_valid_i && op_kind_i == OP_PORT) |=>
        ((port_out[$past(op_port_i)] & ~$past(wr_lanes)) == ($past(port_out[op_port_i]) & ~$past(wr_lanes)));
  endproperty
  a_lane_keep: assert property (p_lane_keep) else $error("unaddressed lane changed");

  property p_sync;
    @(posedge clk_i) disable iff (!resetn_i)
      (up_cnt == UP_DONE) |-> (pin_level_o == $past(gpio_in_i, 2));
  endproperty
  a_sync: assert property (p_sync) else $error("readback not two cycles behind pad");

  property p_read_one;
    @(posedge clk_i) disable iff (!resetn_i)
      rd_valid_i |=> rd_valid_o ##1 (rd_valid_o == $past(rd_valid_i));
  endproperty
  a_read_one: assert property (p_read_one) else $error("read not answered in one cycle");

  property p_event;
    @(posedge clk_i) disable iff (!resetn_i)
      (pm_event_en_i && (|next_pm_hit)) |=> (cpu_event_notify_o && (pm_irq_o != '0));
  endproperty
  a_event: assert property (p_event) else $error("pattern match gave no event");

  c_set_op:  cover property (@(posedge clk_i) disable iff (!resetn_i) op_valid_i && op_kind_i == OP_SET);
  c_toggle:  cover property (@(posedge clk_i) disable iff (!resetn_i) op_valid_i && op_kind_i == OP_NOT);
  c_pattern: cover property (@(posedge clk_i) disable iff (!resetn_i) cpu_event_notify_o);
  c_group:   cover property (@(posedge clk_i) disable iff (!resetn_i) grouped_irq_o[1]);

endmodule : gpio_pin_interrupt_pattern

// ==== verif/pad_board.sv ====
// Board-side model of the pads around the block
module pad_board
  import gpio_pkg::*;
(
  // Block side
  input  wire logic [NUM_PINS-1:0] out_i,
  input  wire logic [NUM_PINS-1:0] oe_i,
  // Board side
  input  wire logic [NUM_PINS-1:0] ext_i,
  output logic [NUM_PINS-1:0]      pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Driven pins read back their own level
  always_comb pad_o = (oe_i & out_i) | (~oe_i & ext_i);
endmodule : pad_board

// ==== verif/gpio_pin_interrupt_pattern_tb.sv ====
// Self-checking bench for the two-port GPIO block
module gpio_pin_interrupt_pattern_tb
  import gpio_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------------
  logic clk_i, resetn_i, op_valid, op_port, rd_valid, rd_port, rd_valid_o, pint_wake_o, notify;
  gpio_op_t op_kind, rd_kind;
  logic [31:0] op_data, rd_data_o, dir[2], out[2], mask[2];
  logic [3:0] op_be, rd_be;
  logic [63:0] ext, pad, gpio_out_o, gpio_oe_o, pin_level_o;
  logic [1:0][63:0] grp_en, grp_high;
  logic [1:0] grp_and, grouped_irq_o;
  logic [7:0][5:0] pint_sel;
  logic [7:0] lvl, rise, fall, ahigh, clr, pint_irq_o, pm_end, pm_irq_o, pm_event_en;
  logic [7:0][2:0] pm_src;
  pm_cond_t [7:0] pm_cond;
  logic [31:0] rd_q[$];
  int fails, total_checks, seed, i;
  gpio_op_t kinds[6] = '{OP_PORT, OP_SET, OP_CLR, OP_NOT, OP_MASK, OP_MPORT};
  // --------------------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------------------
  gpio_pin_interrupt_pattern gpio_pin_interrupt_pattern_inst (
    .clk_i(clk_i), .resetn_i(resetn_i), .op_valid_i(op_valid), .op_kind_i(op_kind), .op_port_i(op_port),
    .op_data_i(op_data), .op_be_i(op_be), .rd_valid_i(rd_valid), .rd_kind_i(rd_kind), .rd_port_i(rd_port),
    .rd_be_i(rd_be), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .gpio_in_i(pad), .gpio_out_o(gpio_out_o),
    .gpio_oe_o(gpio_oe_o), .pin_level_o(pin_level_o), .grp_en_i(grp_en), .grp_high_i(grp_high),
    .grp_and_i(grp_and), .grouped_irq_o(grouped_irq_o), .pint_sel_i(pint_sel), .pint_level_mode_i(lvl),
    .pint_rise_i(rise), .pint_fall_i(fall), .pint_active_high_i(ahigh), .pint_clear_i(clr),
    .pint_irq_o(pint_irq_o), .pint_wake_o(pint_wake_o), .pm_src_i(pm_src), .pm_cond_i(pm_cond),
    .pm_end_i(pm_end), .pm_event_en_i(pm_event_en[0]), .pm_irq_o(pm_irq_o), .cpu_event_notify_o(notify));
  pad_board pad_board_inst (.out_i(gpio_out_o), .oe_i(gpio_oe_o), .ext_i(ext), .pad_o(pad));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // --------------------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------------------
  task automatic test_done;
    if (fails == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  always @(posedge clk_i) begin
    if (rd_valid_o === 1'b1) begin
      if (rd_q.size() == 0) check("rd_extra", 64'h0, 64'h1);
      else check("rd_data", {32'h0, rd_q.pop_front()}, {32'h0, rd_data_o});
    end
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    test_done();
  end
  // --------------------------------------------------------------------------
  // Drivers with expected-value model
  // --------------------------------------------------------------------------
  function automatic logic [31:0] lanes(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : lanes
  function automatic logic [31:0] exp_pad(input logic p);
    logic [63:0] v;
    v = ({dir[1], dir[0]} & {out[1], out[0]}) | (~{dir[1], dir[0]} & ext);
    return p ? v[63:32] : v[31:0];
  endfunction : exp_pad
  task automatic wr(input gpio_op_t k, input logic p, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] le;
    le = lanes(be);
    rd_valid = 1'b0;
    op_valid = 1'b1; op_kind = k; op_port = p; op_data = d; op_be = be;
    case (k)
      OP_DIR:   dir[p] = (dir[p] & ~le) | (d & le);
      OP_MASK:  mask[p] = (mask[p] & ~le) | (d & le);
      OP_PORT:  out[p] = (out[p] & ~le) | (d & le);
      OP_MPORT: out[p] = (out[p] & ~(le & ~mask[p])) | (d & le & ~mask[p]);
      OP_SET:   out[p] = out[p] | (d & le);
      OP_CLR:   out[p] = out[p] & ~(d & le);
      default:  out[p] = out[p] ^ (d & le);
    endcase
    @(posedge clk_i);
    #1;
  endtask : wr
  task automatic rd(input gpio_op_t k, input logic p, input logic [3:0] be, input logic [31:0] exp);
    op_valid = 1'b0;
    rd_valid = 1'b1; rd_kind = k; rd_port = p; rd_be = be;
    rd_q.push_back(exp & lanes(be));
    @(posedge clk_i);
    #1;
  endtask : rd
  task automatic quiet(input int n);
    op_valid = 1'b0; rd_valid = 1'b0;
    repeat (n) @(posedge clk_i);
    #1;
  endtask : quiet
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    seed = 95; fails = 0; total_checks = 0; resetn_i = 1'b0; ext = 64'h0;
    op_valid = 0; op_kind = OP_DIR; op_port = 0; op_data = 0; op_be = 0;
    rd_valid = 0; rd_kind = OP_DIR; rd_port = 0; rd_be = 0;
    dir = '{2{32'h0}}; out = '{2{32'h0}}; mask = '{2{32'h0}};
    grp_en = '0; grp_high = '0; grp_and = 2'b01; lvl = 8'h08; rise = 8'h0d; fall = 8'h06;
    ahigh = 8'h00; clr = 8'h00; pm_end = 8'h01; pm_event_en = 8'h01; pm_src = '0; pm_cond = '{8{PM_ALWAYS}};
    for (i = 0; i < 8; i++) pint_sel[i] = 6'(40 + i);
    pm_cond[0] = PM_HIGH; pm_cond[1] = PM_RISE; pm_src[1] = 3'h1;
    grp_en[0][45:44] = 2'b11; grp_high[0][45:44] = 2'b11; grp_en[1][44] = 1'b1;
    repeat (8) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    check("oe_reset", 64'h0, gpio_oe_o);
    rd(OP_DIR, 1'b1, 4'hf, 32'h0);
    wr(OP_DIR, 1'b0, 32'hffff_ffff, 4'h3);
    wr(OP_DIR, 1'b1, 32'h00ff_00ff, 4'hf);
    for (i = 0; i < 24; i++) wr(kinds[i % 6], i[1], $random(seed), 4'($random(seed)));
    ext = {$random(seed), $random(seed)};
    quiet(3);
    check("out", {out[1], out[0]}, gpio_out_o);
    check("oe", {dir[1], dir[0]}, gpio_oe_o);
    check("level", {exp_pad(1), exp_pad(0)}, pin_level_o);
    for (i = 0; i < 2; i++) begin
      rd(OP_SET, i[0], 4'hf, out[i]);
      rd(OP_PORT, i[0], 4'h2, exp_pad(i[0]));
      rd(OP_MPORT, i[0], 4'hf, exp_pad(i[0]) & ~mask[i]);
      rd(OP_MASK, i[0], 4'hc, mask[i]);
      rd(OP_CLR, i[0], 4'hf, 32'h0);
    end
    ext[45:40] = 6'b110010;
    #1 check("grp", 64'h1, {62'h0, grouped_irq_o});
    ext[44] = 1'b0;
    #1 check("grp", 64'h2, {62'h0, grouped_irq_o});
    ext[43:40] = 4'h0;
    quiet(4);
    clr = 8'hff;
    quiet(1);
    clr = 8'h00;
    check("irq_idle", 64'h08, {56'h0, pint_irq_o});
    ext[43:40] = 4'hf;
    quiet(3);
    check("irq_rise", 64'h05, {56'h0, pint_irq_o});
    check("pm_irq", 64'h81, {56'h0, pm_irq_o});
    check("notify", 64'h1, {63'h0, notify});
    pm_event_en = 8'h00;
    quiet(1);
    check("pm_irq", 64'h01, {56'h0, pm_irq_o});
    check("notify_off", 64'h0, {63'h0, notify});
    clr = 8'h07;
    quiet(1);
    clr = 8'h00;
    check("irq_clr", 64'h0, {56'h0, pint_irq_o});
    pm_cond[0] = PM_LOW; pm_cond[1] = PM_EDGE; pm_cond[2] = PM_FALL; pm_src[2] = 3'h2;
    ext[43:40] = 4'h0;
    quiet(3);
    check("irq_fall", 64'h0e, {56'h0, pint_irq_o});
    check("pm_fall", 64'h81, {56'h0, pm_irq_o});
    check("wake", 64'h1, {63'h0, pint_wake_o});
    quiet(2);
    check("rd_left", 64'h0, 64'(rd_q.size()));
    test_done();
  end
endmodule : gpio_pin_interrupt_pattern_tb
